// [rfe_reporter.sv]
/*
 * rfe_reporter: command interpreter that tracks setup, initiate and fetch, keeps
 * the pending error, switches native mode and streams fetch replies to the bus.
 * Assumes an upstream parser on core_clk_i delivering one decoded command per
 * strobe, a measurement engine giving done or timeout pulses, and a bus talker
 * that takes a byte when tx_valid_o and tx_ready_i are both high.
 */
// Functional notes
// RL1: with no errors, fetch reply is the measurement value followed by cr lf.
// RL2: a syntax error since the last talk gives the fault-prefixed line instead.
// RL3: measurement timeout gives a timeout-prefixed fault line on fetch.
// RL4: measurement data is captured into the reply only when fetch is acknowledged.
// RL5: value field carries only digits, signs, point and E; nothing else is sent.
// RL6: native-mode command routes following strings to the native command set.
// RL7: only the language return command leaves native mode.
// RL8: bus device clear never leaves native mode.
// RL9: controller waits for processing of language return, watching service request.
// RL10: an error shows on the display and goes out on the next talk address.
// RL11: no-signal error uses timeout text; other errors use fault prefix and number.
// RL12: error 08 is built-in test fail; 52 to 55 are illegal entries.
// RL13: errors 75 to 82 are parser syntax faults, reported by number.
// RL14: 85 setup mismatch, 86 initiate mismatch, 87 no setup, 88 bad combination.
// RL15: fetch measurement character must match the last initiate, else error.
// RL16: fetch right after confidence, built-in test or reset raises an error.
// RL17: a pending error is cleared once its reply has been fully sent.
`timescale 1ns/10ps
module rfe_reporter
  import rfe_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire rfe_cmd_type cmd_code_i,
  input wire logic [7:0] cmd_mchar_i,
  input wire logic error_valid_i,
  input wire logic [7:0] error_code_i,
  input wire logic meas_done_i,
  input wire logic meas_timeout_i,
  input wire logic [8*RFE_VAL_CHARS-1:0] meas_value_i,
  input wire logic talk_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic initiate_o,
  output logic fetch_ack_o,
  output logic native_mode_o,
  output logic native_cmd_o,
  output logic lang_done_o,
  output logic [7:0] err_display_o
);

  // ==========================================================================
  // declarations
  rfe_fmt_if fmt ();

  rfe_state_type state_r, state_nxt;
  rfe_reply_type kind_r, kind_nxt;
  logic [RFE_IDX_W-1:0] idx_r, idx_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic done_r, done_nxt;
  logic native_r, native_nxt;
  logic native_cmd_r, native_cmd_nxt;
  logic lang_done_r, lang_done_nxt;
  logic initiate_r, initiate_nxt;
  logic fetch_ack_r, fetch_ack_nxt;
  logic err_pend_r, err_pend_nxt;
  logic [7:0] err_code_r, err_code_nxt;
  logic [7:0] err_disp_r, err_disp_nxt;
  logic setup_seen_r, setup_seen_nxt;
  logic [7:0] setup_mchar_r, setup_mchar_nxt;
  logic init_seen_r, init_seen_nxt;
  logic [7:0] init_mchar_r, init_mchar_nxt;
  logic after_test_r, after_test_nxt;
  logic fetch_pend_r, fetch_pend_nxt;
  logic meas_ok_r, meas_ok_nxt;
  logic meas_tmo_r, meas_tmo_nxt;
  logic [8*RFE_VAL_CHARS-1:0] meas_r, meas_nxt;
  logic [8*RFE_VAL_CHARS-1:0] snap_r, snap_nxt;
  logic new_err;
  logic [7:0] new_code;
  logic reply_end;

  // ==========================================================================
  // character generator
  assign fmt.kind = kind_r;
  assign fmt.idx = idx_r;
  assign fmt.value = snap_r;
  assign fmt.err_code = err_code_r;

  rfe_char_gen u_char_gen (
    .fmt(fmt)
  );

  // ==========================================================================
  // command interpretation and error capture
  always_comb begin
    native_nxt = native_r;
    native_cmd_nxt = 1'b0;
    lang_done_nxt = 1'b0;
    initiate_nxt = 1'b0;
    fetch_ack_nxt = 1'b0;
    setup_seen_nxt = setup_seen_r;
    setup_mchar_nxt = setup_mchar_r;
    init_seen_nxt = init_seen_r;
    init_mchar_nxt = init_mchar_r;
    after_test_nxt = after_test_r;
    fetch_pend_nxt = fetch_pend_r;
    meas_ok_nxt = meas_ok_r;
    meas_tmo_nxt = meas_tmo_r;
    meas_nxt = meas_r;
    snap_nxt = snap_r;
    new_err = 1'b0;
    new_code = RFE_ERR_NONE;
    // reply end clears first, so a fetch taken in that same cycle stays pending
    if (reply_end) begin
      fetch_pend_nxt = 1'b0; // RL17
    end
    // parser-reported errors such as 08, 52-55, 75-82 and 88 pass straight in
    if (error_valid_i) begin
      new_err = 1'b1; // RL12 RL13 RL14
      new_code = error_code_i;
    end
    // measurement engine results for the last initiate
    if (meas_done_i) begin
      meas_ok_nxt = 1'b1;
      meas_tmo_nxt = 1'b0;
      meas_nxt = meas_value_i;
    end
    if (meas_timeout_i) begin
      meas_tmo_nxt = 1'b1; // RL3
      meas_ok_nxt = 1'b0;
    end
    if (cmd_valid_i) begin
      if (native_r) begin
        // device clear is not a way out; only the return string is
        if (cmd_code_i == RFE_CMD_LANG_RET) begin
          native_nxt = 1'b0; // RL7
          lang_done_nxt = 1'b1; // RL9
        end else begin
          native_cmd_nxt = 1'b1; // RL6 RL8
        end
      end else begin
        after_test_nxt = 1'b0;
        case (cmd_code_i)
          RFE_CMD_SETUP: begin
            setup_seen_nxt = 1'b1;
            setup_mchar_nxt = cmd_mchar_i;
          end
          RFE_CMD_INIT: begin
            if (!setup_seen_r) begin
              new_err = 1'b1;
              new_code = RFE_ERR_NO_SETUP; // RL14
            end else if (cmd_mchar_i != setup_mchar_r) begin
              new_err = 1'b1;
              new_code = RFE_ERR_SETUP_MISMATCH; // RL14
            end else begin
              initiate_nxt = 1'b1;
              init_seen_nxt = 1'b1;
              init_mchar_nxt = cmd_mchar_i;
              meas_ok_nxt = 1'b0;
              meas_tmo_nxt = 1'b0;
            end
          end
          RFE_CMD_FETCH: begin
            fetch_ack_nxt = 1'b1;
            fetch_pend_nxt = 1'b1;
            // data is frozen for formatting only now
            snap_nxt = meas_r; // RL4
            if (after_test_r || !init_seen_r) begin
              new_err = 1'b1;
              new_code = RFE_ERR_NO_SETUP; // RL16
            end else if (cmd_mchar_i != init_mchar_r) begin
              new_err = 1'b1;
              new_code = RFE_ERR_INIT_MISMATCH; // RL15
            end
          end
          RFE_CMD_NATIVE: begin
            native_nxt = 1'b1; // RL6
          end
          RFE_CMD_CONF, RFE_CMD_BIT, RFE_CMD_RESET: begin
            after_test_nxt = 1'b1; // RL16
            init_seen_nxt = 1'b0;
          end
          default: begin
            after_test_nxt = 1'b0;
          end
        endcase
      end
    end
  end

  // pending error: a new error in the clearing cycle survives
  always_comb begin
    err_pend_nxt = err_pend_r;
    err_code_nxt = err_code_r;
    err_disp_nxt = err_disp_r;
    if (reply_end && kind_r == RFE_RPL_FAULT) begin
      err_pend_nxt = 1'b0; // RL17
    end
    if (new_err) begin
      err_pend_nxt = 1'b1; // RL10
      err_code_nxt = new_code;
      err_disp_nxt = new_code; // RL10
    end else if (meas_timeout_i) begin
      err_disp_nxt = RFE_ERR_NO_SIGNAL; // RL11
    end
  end

  // ==========================================================================
  // reply transmitter
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    idx_nxt = idx_r;
    tx_data_nxt = tx_data_r;
    tx_valid_nxt = tx_valid_r;
    done_nxt = done_r;
    reply_end = 1'b0;
    case (state_r)
      RFE_ST_IDLE: begin
        if (talk_i) begin
          state_nxt = RFE_ST_SEND;
          idx_nxt = '0;
          done_nxt = 1'b0;
          // errors outrank timeout, timeout outranks the value
          if (err_pend_r) begin
            kind_nxt = RFE_RPL_FAULT; // RL2 RL10
          end else if (fetch_pend_r && meas_tmo_r) begin
            kind_nxt = RFE_RPL_TMO; // RL3
          end else if (fetch_pend_r && meas_ok_r) begin
            kind_nxt = RFE_RPL_VALUE; // RL1
          end else begin
            kind_nxt = RFE_RPL_EMPTY;
          end
        end
      end
      RFE_ST_SEND: begin
        if (!tx_valid_r || tx_ready_i) begin
          if (done_r) begin
            tx_valid_nxt = 1'b0;
            state_nxt = RFE_ST_IDLE;
            reply_end = 1'b1; // RL17
          end else begin
            tx_data_nxt = fmt.char;
            tx_valid_nxt = !fmt.skip; // RL5
            idx_nxt = idx_r + RFE_IDX_W'(1);
            done_nxt = fmt.last;
          end
        end
      end
      default: begin
        state_nxt = RFE_ST_IDLE;
        tx_valid_nxt = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= RFE_ST_IDLE;
      kind_r <= RFE_RPL_EMPTY;
      idx_r <= '0;
      tx_data_r <= 8'h00;
      tx_valid_r <= 1'b0;
      done_r <= 1'b0;
      native_r <= 1'b0;
      native_cmd_r <= 1'b0;
      lang_done_r <= 1'b0;
      initiate_r <= 1'b0;
      fetch_ack_r <= 1'b0;
      err_pend_r <= 1'b0;
      err_code_r <= RFE_ERR_NONE;
      err_disp_r <= RFE_ERR_NONE;
      setup_seen_r <= 1'b0;
      setup_mchar_r <= 8'h00;
      init_seen_r <= 1'b0;
      init_mchar_r <= 8'h00;
      after_test_r <= 1'b0;
      fetch_pend_r <= 1'b0;
      meas_ok_r <= 1'b0;
      meas_tmo_r <= 1'b0;
      meas_r <= '0;
      snap_r <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      idx_r <= idx_nxt;
      tx_data_r <= tx_data_nxt;
      tx_valid_r <= tx_valid_nxt;
      done_r <= done_nxt;
      native_r <= native_nxt;
      native_cmd_r <= native_cmd_nxt;
      lang_done_r <= lang_done_nxt;
      initiate_r <= initiate_nxt;
      fetch_ack_r <= fetch_ack_nxt;
      err_pend_r <= err_pend_nxt;
      err_code_r <= err_code_nxt;
      err_disp_r <= err_disp_nxt;
      setup_seen_r <= setup_seen_nxt;
      setup_mchar_r <= setup_mchar_nxt;
      init_seen_r <= init_seen_nxt;
      init_mchar_r <= init_mchar_nxt;
      after_test_r <= after_test_nxt;
      fetch_pend_r <= fetch_pend_nxt;
      meas_ok_r <= meas_ok_nxt;
      meas_tmo_r <= meas_tmo_nxt;
      meas_r <= meas_nxt;
      snap_r <= snap_nxt;
    end
  end

  // outputs straight from flops
  assign tx_data_o = tx_data_r;
  assign tx_valid_o = tx_valid_r;
  assign initiate_o = initiate_r;
  assign fetch_ack_o = fetch_ack_r;
  assign native_mode_o = native_r;
  assign native_cmd_o = native_cmd_r;
  assign lang_done_o = lang_done_r;
  assign err_display_o = err_disp_r;

endmodule

// [rfe_pkg.sv]
/*
 * rfe_pkg: shared constants and types for the remote fetch and error reporter.
 * Assumes the command parser upstream delivers decoded commands on the core clock.
 */
package rfe_pkg;

  // ==========================================================================
  // command codes delivered by the parser
  typedef enum logic [3:0] {
    RFE_CMD_SETUP = 4'h0, // measure_setup_command
    RFE_CMD_INIT = 4'h1, // initiate_measure_command
    RFE_CMD_FETCH = 4'h2, // fetch_result_command
    RFE_CMD_NATIVE = 4'h3, // native_mode_command
    RFE_CMD_LANG_RET = 4'h4, // language_return_command
    RFE_CMD_CONF = 4'h5, // confidence_test_command
    RFE_CMD_BIT = 4'h6, // builtin_test_command
    RFE_CMD_RESET = 4'h7, // reset string
    RFE_CMD_DCL = 4'h8, // bus device clear
    RFE_CMD_OTHER = 4'h9 // any other valid string
  } rfe_cmd_type;

  // ==========================================================================
  // reply kinds chosen at talk-address time
  typedef enum logic [1:0] {
    RFE_RPL_EMPTY = 2'h0, // bare cr lf
    RFE_RPL_VALUE = 2'h1,
    RFE_RPL_FAULT = 2'h2,
    RFE_RPL_TMO = 2'h3
  } rfe_reply_type;

  // one-hot transmit states
  typedef enum logic [1:0] {
    RFE_ST_IDLE = 2'b01,
    RFE_ST_SEND = 2'b10
  } rfe_state_type;

  // ==========================================================================
  // error numbers, two bcd digits
  localparam logic [7:0] RFE_ERR_SETUP_MISMATCH = 8'h85;
  localparam logic [7:0] RFE_ERR_INIT_MISMATCH = 8'h86;
  localparam logic [7:0] RFE_ERR_NO_SETUP = 8'h87;
  localparam logic [7:0] RFE_ERR_NO_SIGNAL = 8'h95;
  localparam logic [7:0] RFE_ERR_NONE = 8'h00;

  // ==========================================================================
  // reply texts and lengths
  localparam int RFE_TXT_LEN = 24;
  localparam logic [8*RFE_TXT_LEN-1:0] RFE_FAULT_TXT = "F07PCT1: ERROR NUMBER # ";
  localparam logic [8*RFE_TXT_LEN-1:0] RFE_TMO_TXT = "F05PCT1: NO SIGNAL FOUND";
  localparam int RFE_VAL_CHARS = 12;
  localparam int RFE_IDX_W = 5;
  localparam logic [7:0] RFE_CR = 8'h0d;
  localparam logic [7:0] RFE_LF = 8'h0a;
  localparam logic [7:0] RFE_ASC_0 = 8'h30;
  localparam logic [7:0] RFE_ASC_9 = 8'h39;
  localparam logic [7:0] RFE_ASC_PLUS = 8'h2b;
  localparam logic [7:0] RFE_ASC_MINUS = 8'h2d;
  localparam logic [7:0] RFE_ASC_DOT = 8'h2e;
  localparam logic [7:0] RFE_ASC_E = 8'h45;

endpackage

// [rfe_fmt_if.sv]
/*
 * rfe_fmt_if: carries a reply character request from the reporter to the
 * character generator and the character back.
 * Assumes both ends sit in the same clock domain; the path is combinational.
 */
`timescale 1ns/10ps
interface rfe_fmt_if;
  import rfe_pkg::*;
  rfe_reply_type kind;
  logic [RFE_IDX_W-1:0] idx;
  logic [8*RFE_VAL_CHARS-1:0] value;
  logic [7:0] err_code;
  logic [7:0] char;
  logic skip;
  logic last;

  modport req (output kind, output idx, output value, output err_code, input char, input skip, input last);
  modport gen (input kind, input idx, input value, input err_code, output char, output skip, output last);
endinterface

// [rfe_char_gen.sv]
/*
 * rfe_char_gen: returns the reply character at a given index for each reply kind.
 * Assumes the requester walks the index from zero until last is seen.
 */
`timescale 1ns/10ps
module rfe_char_gen
  import rfe_pkg::*;
(
  rfe_fmt_if.gen fmt
);

  // ==========================================================================
  // character lookup
  logic [7:0] val_ch;

  // value characters are read left to right from the snapshot
  always_comb begin
    val_ch = fmt.value[8*(RFE_VAL_CHARS-1)-8*fmt.idx +: 8];
  end

  always_comb begin
    fmt.char = RFE_CR;
    fmt.skip = 1'b0;
    fmt.last = 1'b0;
    case (fmt.kind)
      RFE_RPL_VALUE: begin
        if (fmt.idx < RFE_IDX_W'(RFE_VAL_CHARS)) begin
          fmt.char = val_ch;
          // anything outside the allowed set, blanks included, never reaches the bus
          fmt.skip = !((val_ch >= RFE_ASC_0 && val_ch <= RFE_ASC_9) || val_ch == RFE_ASC_PLUS ||
                       val_ch == RFE_ASC_MINUS || val_ch == RFE_ASC_DOT || val_ch == RFE_ASC_E); // RL5
        end else if (fmt.idx == RFE_IDX_W'(RFE_VAL_CHARS)) begin
          fmt.char = RFE_CR;
        end else begin
          fmt.char = RFE_LF;
          fmt.last = 1'b1;
        end
      end
      RFE_RPL_FAULT: begin
        // fault prefix, fixed text, two error digits, cr lf
        if (fmt.idx < RFE_IDX_W'(RFE_TXT_LEN)) begin
          fmt.char = RFE_FAULT_TXT[8*(RFE_TXT_LEN-1)-8*fmt.idx +: 8]; // RL2 RL11
        end else if (fmt.idx == RFE_IDX_W'(RFE_TXT_LEN)) begin
          fmt.char = RFE_ASC_0 | {4'h0, fmt.err_code[7:4]};
        end else if (fmt.idx == RFE_IDX_W'(RFE_TXT_LEN + 1)) begin
          fmt.char = RFE_ASC_0 | {4'h0, fmt.err_code[3:0]};
        end else if (fmt.idx == RFE_IDX_W'(RFE_TXT_LEN + 2)) begin
          fmt.char = RFE_CR;
        end else begin
          fmt.char = RFE_LF;
          fmt.last = 1'b1;
        end
      end
      RFE_RPL_TMO: begin
        if (fmt.idx < RFE_IDX_W'(RFE_TXT_LEN)) begin
          fmt.char = RFE_TMO_TXT[8*(RFE_TXT_LEN-1)-8*fmt.idx +: 8]; // RL3 RL11
        end else if (fmt.idx == RFE_IDX_W'(RFE_TXT_LEN)) begin
          fmt.char = RFE_CR;
        end else begin
          fmt.char = RFE_LF;
          fmt.last = 1'b1;
        end
      end
      default: begin
        // empty reply: cr then lf
        fmt.char = (fmt.idx == '0) ? RFE_CR : RFE_LF;
        fmt.last = (fmt.idx != '0);
      end
    endcase
  end

endmodule

// [rfe_reporter_chk.sv]
/* rfe_reporter_chk: concurrent checks on the reporter ports.
   assumes one core clock with synchronous active-high reset. */
`timescale 1ns/10ps
module rfe_reporter_chk
  import rfe_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire rfe_cmd_type cmd_code_i,
  input wire logic [7:0] cmd_mchar_i,
  input wire logic error_valid_i,
  input wire logic [7:0] error_code_i,
  input wire logic meas_done_i,
  input wire logic meas_timeout_i,
  input wire logic [8*RFE_VAL_CHARS-1:0] meas_value_i,
  input wire logic talk_i,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic initiate_o,
  input wire logic fetch_ack_o,
  input wire logic native_mode_o,
  input wire logic native_cmd_o,
  input wire logic lang_done_o,
  input wire logic [7:0] err_display_o
);
  // ==========================================================================
  // single domain, so defaults are declared once
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_FETCH_ACK: assert property (cmd_valid_i && cmd_code_i == RFE_CMD_FETCH && !native_mode_o |=> fetch_ack_o)
    else $error("fetch not acknowledged");
  AST_NATIVE_ENTER: assert property (cmd_valid_i && cmd_code_i == RFE_CMD_NATIVE |=> native_mode_o)
    else $error("native mode not entered");
  AST_NATIVE_CMD: assert property (native_mode_o && cmd_valid_i && cmd_code_i != RFE_CMD_LANG_RET
    |=> native_cmd_o && native_mode_o && !fetch_ack_o && !initiate_o)
    else $error("native string mishandled");
  AST_NATIVE_EXIT: assert property (native_mode_o && cmd_valid_i && cmd_code_i == RFE_CMD_LANG_RET
    |=> !native_mode_o && lang_done_o)
    else $error("language return not processed");
  AST_NATIVE_HOLD: assert property ($fell(native_mode_o) |-> $past(cmd_valid_i && cmd_code_i == RFE_CMD_LANG_RET))
    else $error("native mode left without language return");
  AST_ERR_SHOW: assert property (error_valid_i && !cmd_valid_i && !meas_timeout_i
    |=> err_display_o == $past(error_code_i))
    else $error("error number not displayed");
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped while stalled");
  // talk is only taken in idle, so require quiet history
  AST_TALK_REPLY: assert property (talk_i && !tx_valid_o && !$past(tx_valid_o) && !$past(tx_valid_o, 2)
    && !$past(talk_i) |-> ##[1:20] tx_valid_o)
    else $error("no reply after talk address");
  AST_INIT_SRC: assert property (initiate_o |-> $past(cmd_valid_i && cmd_code_i == RFE_CMD_INIT && !native_mode_o))
    else $error("initiate without command");
endmodule

bind rfe_reporter rfe_reporter_chk u_rfe_reporter_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_mchar_i(cmd_mchar_i),
  .error_valid_i(error_valid_i), .error_code_i(error_code_i), .meas_done_i(meas_done_i),
  .meas_timeout_i(meas_timeout_i), .meas_value_i(meas_value_i), .talk_i(talk_i),
  .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .initiate_o(initiate_o),
  .fetch_ack_o(fetch_ack_o), .native_mode_o(native_mode_o), .native_cmd_o(native_cmd_o),
  .lang_done_o(lang_done_o), .err_display_o(err_display_o));

// [rfe_bus_ctrl.sv]
/* rfe_bus_ctrl: control computer taking reply bytes off the bus.
   assumes the reporter holds each byte until ready is seen high. */
`timescale 1ns/10ps
module rfe_bus_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  output logic tx_ready_o
);
  // ==========================================================================
  // slow mode stalls at random so held bytes get exercised
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= !slow_i || ($urandom % 3 == 0);
    end
  end
endmodule

// [testbench.sv]
/* testbench: drives commands, errors and measurements into the reporter
   and checks every reply line. assumes rfe_bus_ctrl as the bus talker. */
`timescale 1ns/10ps
module testbench;
  import rfe_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  rfe_cmd_type cmd_code_i = RFE_CMD_OTHER;
  logic [7:0] cmd_mchar_i = 8'h00;
  logic error_valid_i = 1'b0;
  logic [7:0] error_code_i = 8'h00;
  logic meas_done_i = 1'b0;
  logic meas_timeout_i = 1'b0;
  logic [8*RFE_VAL_CHARS-1:0] meas_value_i = '0;
  logic talk_i = 1'b0;
  logic slow = 1'b0;
  logic tx_ready_i;
  logic [7:0] tx_data_o;
  logic tx_valid_o, initiate_o, fetch_ack_o, native_mode_o, native_cmd_o, lang_done_o;
  logic [7:0] err_display_o;
  int mismatches = 0;
  int compares = 0;
  int lines_seen = 0;
  string exp_q[$];
  string line = "";
  string got_e;
  string crlf;
  logic [7:0] codes [14] = '{8'h08, 8'h52, 8'h53, 8'h54, 8'h55, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
    8'h80, 8'h81, 8'h82, 8'h88};
  rfe_cmd_type busy [3] = '{RFE_CMD_CONF, RFE_CMD_BIT, RFE_CMD_RESET};
  rfe_cmd_type nat [4] = '{RFE_CMD_OTHER, RFE_CMD_DCL, RFE_CMD_FETCH, RFE_CMD_INIT};

  always #2.5 core_clk_i = ~core_clk_i;

  rfe_reporter u_rfe_reporter (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_mchar_i(cmd_mchar_i), .error_valid_i(error_valid_i),
    .error_code_i(error_code_i), .meas_done_i(meas_done_i), .meas_timeout_i(meas_timeout_i),
    .meas_value_i(meas_value_i), .talk_i(talk_i), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .initiate_o(initiate_o), .fetch_ack_o(fetch_ack_o),
    .native_mode_o(native_mode_o), .native_cmd_o(native_cmd_o), .lang_done_o(lang_done_o),
    .err_display_o(err_display_o));
  rfe_bus_ctrl u_rfe_bus_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow), .tx_ready_o(tx_ready_i));

  // ==========================================================================
  // helpers
  function automatic string show(string s);
    return s.substr(0, s.len() - 3);
  endfunction
  function automatic string flt(logic [7:0] c);
    return $sformatf("F07PCT1: ERROR NUMBER # %h", c);
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(rfe_cmd_type c, logic [7:0] m);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= c;
    cmd_mchar_i <= m;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask
  task automatic error(logic [7:0] c);
    @(posedge core_clk_i);
    error_valid_i <= 1'b1;
    error_code_i <= c;
    @(posedge core_clk_i);
    error_valid_i <= 1'b0;
    #1;
  endtask
  // random value drawn from the legal set plus blanks; blanks must vanish
  task automatic measure(logic tmo, output string v);
    string set;
    logic [7:0] ch;
    set = "0123456789+-.E ";
    v = "";
    @(posedge core_clk_i);
    for (int k = 0; k < RFE_VAL_CHARS; k++) begin
      ch = set[$urandom % 15];
      meas_value_i[8*(RFE_VAL_CHARS-1-k) +: 8] <= ch;
      if (ch != 8'h20) v = $sformatf("%s%c", v, ch);
    end
    meas_done_i <= !tmo;
    meas_timeout_i <= tmo;
    @(posedge core_clk_i);
    meas_done_i <= 1'b0;
    meas_timeout_i <= 1'b0;
    #1;
  endtask
  // expectation noted before the talk; wait is bounded for a hang
  task automatic talk(string exp);
    int n;
    n = lines_seen;
    @(posedge core_clk_i);
    exp_q.push_back({exp, crlf});
    talk_i <= 1'b1;
    @(posedge core_clk_i);
    talk_i <= 1'b0;
    for (int i = 0; i < 400 && lines_seen == n; i++) @(posedge core_clk_i);
    chk("reply arrived", 8'h01, {7'h00, lines_seen != n});
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // monitor: gathers accepted bytes and compares whole lines
  always @(posedge core_clk_i) begin
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      line = $sformatf("%s%c", line, tx_data_o);
      if (tx_data_o === RFE_LF) begin
        got_e = (exp_q.size() > 0) ? exp_q.pop_front() : crlf;
        compares++;
        if (line != got_e) begin
          mismatches++;
          $display("BAD reply expected %s seen %s", show(got_e), show(line));
        end
        line = "";
        lines_seen++;
      end
    end
  end

  // ==========================================================================
  // watchdog: generous against the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge core_clk_i);
    mismatches++;
    $display("watchdog expired");
    report_and_stop();
  end

  // ==========================================================================
  // main sequence
  initial begin
    string v;
    void'($urandom(97));
    crlf = $sformatf("%c%c", RFE_CR, RFE_LF);
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      slow = r[0];
      cmd(RFE_CMD_SETUP, 8'h46);
      cmd(RFE_CMD_INIT, 8'h46);
      chk("initiate", 8'h01, {7'h00, initiate_o});
      measure(1'b0, v);
      cmd(RFE_CMD_FETCH, 8'h46);
      chk("fetch ack", 8'h01, {7'h00, fetch_ack_o});
      talk(v);
      talk("");
    end
    $display("value replies done");
    foreach (codes[i]) begin
      error(codes[i]);
      chk("display", codes[i], err_display_o);
      cmd(RFE_CMD_INIT, 8'h46);
      measure(1'b0, v);
      cmd(RFE_CMD_FETCH, 8'h46);
      talk(flt(codes[i]));
    end
    $display("error replies done");
    cmd(RFE_CMD_INIT, 8'h46);
    measure(1'b1, v);
    cmd(RFE_CMD_FETCH, 8'h46);
    talk("F05PCT1: NO SIGNAL FOUND");
    chk("display", 8'h95, err_display_o);
    $display("timeout reply done");
    cmd(RFE_CMD_INIT, 8'h47);
    chk("initiate refused", 8'h00, {7'h00, initiate_o});
    talk(flt(8'h85));
    cmd(RFE_CMD_INIT, 8'h46);
    measure(1'b0, v);
    cmd(RFE_CMD_FETCH, 8'h47);
    talk(flt(8'h86));
    foreach (busy[i]) begin
      cmd(RFE_CMD_INIT, 8'h46);
      measure(1'b0, v);
      cmd(busy[i], 8'h46);
      cmd(RFE_CMD_FETCH, 8'h46);
      talk(flt(8'h87));
    end
    $display("refusal replies done");
    cmd(RFE_CMD_NATIVE, 8'h00);
    chk("native on", 8'h01, {7'h00, native_mode_o});
    foreach (nat[i]) begin
      cmd(nat[i], 8'h46);
      chk("native string", 8'h01, {7'h00, native_cmd_o});
      chk("native kept", 8'h01, {7'h00, native_mode_o});
    end
    talk("");
    cmd(RFE_CMD_LANG_RET, 8'h00);
    chk("language done", 8'h01, {7'h00, lang_done_o});
    chk("native off", 8'h00, {7'h00, native_mode_o});
    $display("native mode done");
    report_and_stop();
  end
endmodule
